// [rtl/rsc_pkg.sv]
`default_nettype none
package rsc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_STROBE = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_EVFLAG = 8'h0C;
  localparam logic [7:0] OFS_EVMASK = 8'h10;
  localparam logic [7:0] OFS_CPUFLG = 8'h14;
  localparam logic [7:0] OFS_IRQEN  = 8'h18;

  // strobe codes
  localparam logic [7:0] synth_on_strobe  = 8'h00;
  localparam logic [7:0] calibrate_strobe = 8'h01;
  localparam logic [7:0] receive_strobe   = 8'h02;
  localparam logic [7:0] transmit_strobe  = 8'h03;
  localparam logic [7:0] idle_strobe      = 8'h04;

  // field positions
  localparam int CFG_AUTOCAL  = 0;
  localparam int CFG_CCA      = 1;
  localparam int CPU_DATA     = 0;
  localparam int CPU_GENERAL  = 1;
  localparam int EV_TXUNF     = 7;
  localparam int EV_RXOVF     = 6;
  localparam int EV_TIMEOUT   = 5;
  localparam int EV_DONE      = 4;
  localparam int EV_CS        = 3;
  localparam int EV_PQT       = 2;
  localparam int EV_CCA       = 1;
  localparam int EV_SYNC      = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // radio states, one-hot
  typedef enum logic [8:0] {
    RSC_IDLE   = 9'h001,
    RSC_CALOFF = 9'h002,
    RSC_CALFS  = 9'h004,
    RSC_CALRX  = 9'h008,
    RSC_CALTX  = 9'h010,
    RSC_FSON   = 9'h020,
    RSC_RX     = 9'h040,
    RSC_TX     = 9'h080,
    RSC_ERR    = 9'h100
  } rsc_state_e;

  // controls towards the analog radio
  typedef struct packed {
    logic synth_on;
    logic calibrate;
    logic rx_on;
    logic tx_on;
  } rsc_ctl_s;

  // status from the radio baseband
  typedef struct packed {
    logic [7:0] events;
    logic       channel_clear;
    logic       cal_done;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       tx_req;
  } rsc_sts_s;
endpackage : rsc_pkg
`default_nettype wire

// [rtl/rsc_top.sv]
// Operation
// - one-byte strobes; unknown codes do nothing
// - code 0x00 enables synth, calibrates if set
// - code 0x01 calibrates then powers synth off
// - code 0x02 enters receive, calibrating from idle if set
// - code 0x03 from idle enters transmit
// - transmit from receive with cca needs clear
// - code 0x04 returns idle, synth off
// - data port separate from config registers
// - two interrupt outputs, data and general
// - data flag set on rx byte, tx space
// - data request needs flag and enable
// - events trigger on rising edges only
// - eight sticky event flags
// - masked event sets general flag, gated request
// - event flag byte layout, write zero clears
`timescale 1ns/100ps
`default_nettype none
module rsc_top (
  // clock and reset
  input  wire  logic              pclk,
  input  wire  logic              presetn,
  // apb slave
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [7:0]        paddr,
  input  wire  logic [31:0]       pwdata,
  output var   logic [31:0]       prdata,
  output var   logic              pready,
  output var   logic              pslverr,
  // radio side
  input  wire  rsc_pkg::rsc_sts_s sts,
  output var   rsc_pkg::rsc_ctl_s ctl,
  output var   logic [7:0]        tx_byte,
  // interrupts
  output var   logic              irq_data_transfer,
  output var   logic              irq_general
);
  rsc_pkg::rsc_state_e state, next_state;
  rsc_pkg::rsc_ctl_s   next_ctl;
  logic [7:0]  strobe_command_reg, next_strobe;
  logic        strobe_pend, next_strobe_pend;
  logic [1:0]  config_reg, next_config;
  logic [7:0]  rx_data, next_rx_data;
  logic        rx_full, next_rx_full;
  logic [7:0]  tx_data, next_tx_data;
  logic        tx_full, next_tx_full;
  logic [7:0]  next_tx_byte;
  logic [7:0]  radio_event_flags, next_flags;
  logic [7:0]  radio_event_mask, next_mask;
  logic [7:0]  prev_events;
  logic [1:0]  cpu_flags, next_cpu;
  logic [1:0]  irq_enable, next_irqen;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq_d, next_irq_g;
  logic        wr, rd, setup, mapped, autocal, cca;
  logic [7:0]  ev_set, ev_rise;

  // bus decode; an access completes at the edge where pready is high
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready & pwrite;
  assign rd     = psel & penable & pready & ~pwrite;
  assign mapped = (paddr == rsc_pkg::OFS_STROBE) |
                  (paddr == rsc_pkg::OFS_CONFIG) |
                  (paddr == rsc_pkg::OFS_DATA)   |
                  (paddr == rsc_pkg::OFS_EVFLAG) |
                  (paddr == rsc_pkg::OFS_EVMASK) |
                  (paddr == rsc_pkg::OFS_CPUFLG) |
                  (paddr == rsc_pkg::OFS_IRQEN);
  assign autocal = config_reg[rsc_pkg::CFG_AUTOCAL];
  assign cca     = config_reg[rsc_pkg::CFG_CCA];
  assign ev_rise = sts.events & ~prev_events;

  // next-value logic for bus, data port, flags and radio state
  always_comb begin
    next_prdata      = prdata;
    next_pready      = setup;
    next_pslverr     = setup & ~mapped;
    next_strobe      = strobe_command_reg;
    next_strobe_pend = 1'b0;
    next_config      = config_reg;
    next_mask        = radio_event_mask;
    next_irqen       = irq_enable;
    next_rx_data     = rx_data;
    next_rx_full     = rx_full;
    next_tx_data     = tx_data;
    next_tx_full     = tx_full;
    next_tx_byte     = tx_byte;
    next_state       = state;
    next_flags       = radio_event_flags;
    next_cpu         = cpu_flags;
    ev_set           = ev_rise;
    // read data is captured in the setup cycle, one wait-free access
    if (setup) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        rsc_pkg::OFS_STROBE: next_prdata = {23'h000000, state};
        rsc_pkg::OFS_CONFIG: next_prdata = {30'h00000000, config_reg};
        rsc_pkg::OFS_DATA:   next_prdata = {24'h000000, rx_data};
        rsc_pkg::OFS_EVFLAG: next_prdata = {24'h000000, radio_event_flags};
        rsc_pkg::OFS_EVMASK: next_prdata = {24'h000000, radio_event_mask};
        rsc_pkg::OFS_CPUFLG: next_prdata = {30'h00000000, cpu_flags};
        rsc_pkg::OFS_IRQEN:  next_prdata = {30'h00000000, irq_enable};
        default:             next_prdata = 32'h0000_0000;
      endcase
    end
    // register writes; the strobe is latched and acted on next cycle
    if (wr) begin
      unique case (paddr)
        rsc_pkg::OFS_STROBE: begin
          next_strobe      = pwdata[7:0];
          next_strobe_pend = 1'b1;
        end
        rsc_pkg::OFS_CONFIG: next_config = pwdata[1:0];
        rsc_pkg::OFS_DATA: begin
          next_tx_data = pwdata[7:0];
          next_tx_full = 1'b1;
        end
        rsc_pkg::OFS_EVFLAG: begin
          next_flags = radio_event_flags & pwdata[7:0];
        end
        rsc_pkg::OFS_EVMASK: next_mask = pwdata[7:0];
        rsc_pkg::OFS_CPUFLG: next_cpu = cpu_flags & ~pwdata[1:0];
        rsc_pkg::OFS_IRQEN:  next_irqen = pwdata[1:0];
        default:             next_strobe_pend = 1'b0;
      endcase
    end
    // reading the data port frees it for the next received byte
    if (rd && paddr == rsc_pkg::OFS_DATA) begin
      next_rx_full = 1'b0;
    end
    // received byte: overflow if the previous one was not read
    if (sts.rx_valid && state == rsc_pkg::RSC_RX) begin
      if (rx_full) begin
        ev_set[rsc_pkg::EV_RXOVF] = 1'b1;
        ev_set[rsc_pkg::EV_DONE]  = 1'b1;
        next_state = rsc_pkg::RSC_ERR;
      end else begin
        next_rx_data = sts.rx_byte;
        next_rx_full = 1'b1;
        next_cpu[rsc_pkg::CPU_DATA] = 1'b1;
      end
    end
    // transmitter wants a byte: hand it over or underflow
    if (sts.tx_req && state == rsc_pkg::RSC_TX) begin
      if (tx_full) begin
        next_tx_byte = tx_data;
        next_tx_full = 1'b0;
        next_cpu[rsc_pkg::CPU_DATA] = 1'b1;
      end else begin
        ev_set[rsc_pkg::EV_TXUNF] = 1'b1;
        ev_set[rsc_pkg::EV_DONE]  = 1'b1;
        next_state = rsc_pkg::RSC_ERR;
      end
    end
    // calibration completion moves on to the chosen target
    if (sts.cal_done) begin
      unique case (state)
        rsc_pkg::RSC_CALOFF: next_state = rsc_pkg::RSC_IDLE;
        rsc_pkg::RSC_CALFS:  next_state = rsc_pkg::RSC_FSON;
        rsc_pkg::RSC_CALRX:  next_state = rsc_pkg::RSC_RX;
        rsc_pkg::RSC_CALTX:  next_state = rsc_pkg::RSC_TX;
        default:             next_state = next_state;
      endcase
    end
    // strobe decode; codes not listed leave the state alone
    if (strobe_pend) begin
      unique case (strobe_command_reg)
        rsc_pkg::synth_on_strobe: begin
          if (state == rsc_pkg::RSC_IDLE) begin
            next_state = autocal ? rsc_pkg::RSC_CALFS
                                 : rsc_pkg::RSC_FSON;
          end else if (state == rsc_pkg::RSC_RX && cca) begin
            next_state = rsc_pkg::RSC_FSON;
          end
        end
        rsc_pkg::calibrate_strobe: begin
          if (state == rsc_pkg::RSC_IDLE) begin
            next_state = rsc_pkg::RSC_CALOFF;
          end
        end
        rsc_pkg::receive_strobe: begin
          if (state == rsc_pkg::RSC_IDLE) begin
            next_state = autocal ? rsc_pkg::RSC_CALRX
                                 : rsc_pkg::RSC_RX;
          end else if (state == rsc_pkg::RSC_FSON) begin
            next_state = rsc_pkg::RSC_RX;
          end
        end
        rsc_pkg::transmit_strobe: begin
          if (state == rsc_pkg::RSC_IDLE) begin
            next_state = autocal ? rsc_pkg::RSC_CALTX
                                 : rsc_pkg::RSC_TX;
          end else if (state == rsc_pkg::RSC_RX) begin
            if (!cca || sts.channel_clear) begin
              next_state = rsc_pkg::RSC_TX;
            end
          end else if (state == rsc_pkg::RSC_FSON) begin
            next_state = rsc_pkg::RSC_TX;
          end
        end
        // the only way out of the overflow/underflow state
        rsc_pkg::idle_strobe: next_state = rsc_pkg::RSC_IDLE;
        default:              next_state = next_state;
      endcase
    end
    // entering transmit with room in the data port asks for a byte
    if (next_state == rsc_pkg::RSC_TX && state != rsc_pkg::RSC_TX &&
        !next_tx_full) begin
      next_cpu[rsc_pkg::CPU_DATA] = 1'b1;
    end
    // set beats a clear landing in the same cycle
    next_flags = next_flags | ev_set;
    if ((ev_set & radio_event_mask) != 8'h00) begin
      next_cpu[rsc_pkg::CPU_GENERAL] = 1'b1;
    end
    next_irq_d = next_cpu[rsc_pkg::CPU_DATA] &
                 next_irqen[rsc_pkg::CPU_DATA];
    next_irq_g = next_cpu[rsc_pkg::CPU_GENERAL] &
                 next_irqen[rsc_pkg::CPU_GENERAL];
    // analog controls follow the next state so they leave a flop
    next_ctl.synth_on  = (next_state != rsc_pkg::RSC_IDLE) &&
                         (next_state != rsc_pkg::RSC_ERR);
    next_ctl.calibrate = (next_state == rsc_pkg::RSC_CALOFF) ||
                         (next_state == rsc_pkg::RSC_CALFS) ||
                         (next_state == rsc_pkg::RSC_CALRX) ||
                         (next_state == rsc_pkg::RSC_CALTX);
    next_ctl.rx_on     = (next_state == rsc_pkg::RSC_RX);
    next_ctl.tx_on     = (next_state == rsc_pkg::RSC_TX);
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= rsc_pkg::RSC_IDLE;
      ctl                <= '0;
      strobe_command_reg <= rsc_pkg::RST_BYTE;
      strobe_pend        <= 1'b0;
      config_reg         <= rsc_pkg::RST_PAIR;
      rx_data            <= rsc_pkg::RST_BYTE;
      rx_full            <= 1'b0;
      tx_data            <= rsc_pkg::RST_BYTE;
      tx_full            <= 1'b0;
      tx_byte            <= rsc_pkg::RST_BYTE;
      radio_event_flags  <= rsc_pkg::RST_BYTE;
      radio_event_mask   <= rsc_pkg::RST_BYTE;
      prev_events        <= rsc_pkg::RST_BYTE;
      cpu_flags          <= rsc_pkg::RST_PAIR;
      irq_enable         <= rsc_pkg::RST_PAIR;
      prdata             <= 32'h0000_0000;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      irq_data_transfer  <= 1'b0;
      irq_general        <= 1'b0;
    end else begin
      state              <= next_state;
      ctl                <= next_ctl;
      strobe_command_reg <= next_strobe;
      strobe_pend        <= next_strobe_pend;
      config_reg         <= next_config;
      rx_data            <= next_rx_data;
      rx_full            <= next_rx_full;
      tx_data            <= next_tx_data;
      tx_full            <= next_tx_full;
      tx_byte            <= next_tx_byte;
      radio_event_flags  <= next_flags;
      radio_event_mask   <= next_mask;
      prev_events        <= sts.events;
      cpu_flags          <= next_cpu;
      irq_enable         <= next_irqen;
      prdata             <= next_prdata;
      pready             <= next_pready;
      pslverr            <= next_pslverr;
      irq_data_transfer  <= next_irq_d;
      irq_general        <= next_irq_g;
    end
  end

  // checks
  strobe_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == rsc_pkg::OFS_STROBE |=> strobe_pend)
    else $error("strobe not pending after write");
  idle_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_pend && strobe_command_reg == rsc_pkg::idle_strobe
    |=> state == rsc_pkg::RSC_IDLE && !ctl.synth_on)
    else $error("idle strobe did not reach idle");
  nop_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_pend && strobe_command_reg > rsc_pkg::idle_strobe &&
    !sts.cal_done && !sts.rx_valid && !sts.tx_req
    |=> $stable(state))
    else $error("unknown strobe changed state");
  cal_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_pend && strobe_command_reg == rsc_pkg::calibrate_strobe &&
    state == rsc_pkg::RSC_IDLE |=> state == rsc_pkg::RSC_CALOFF ##1
    ctl.calibrate)
    else $error("calibrate strobe ignored in idle");
  rx_autocal_a: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_pend && strobe_command_reg == rsc_pkg::receive_strobe &&
    state == rsc_pkg::RSC_IDLE |=> state == (autocal ?
    rsc_pkg::RSC_CALRX : rsc_pkg::RSC_RX))
    else $error("receive strobe wrong target");
  cca_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_pend && strobe_command_reg == rsc_pkg::transmit_strobe &&
    state == rsc_pkg::RSC_RX && cca && !sts.channel_clear &&
    !sts.rx_valid |=> state == rsc_pkg::RSC_RX)
    else $error("transmit taken on busy channel");
  edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $stable(sts.events) && !(wr && paddr == rsc_pkg::OFS_EVFLAG) &&
    !sts.rx_valid && !sts.tx_req |=> $stable(radio_event_flags))
    else $error("flag set without rising edge");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_rise != 8'h00) |=> (radio_event_flags & $past(ev_rise))
    == $past(ev_rise))
    else $error("event flag lost");
  gen_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((ev_rise & radio_event_mask) != 8'h00) &&
    irq_enable[rsc_pkg::CPU_GENERAL] &&
    !(wr && paddr == rsc_pkg::OFS_IRQEN) |=> irq_general)
    else $error("general interrupt missing");
  data_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_data_transfer |-> cpu_flags[rsc_pkg::CPU_DATA] &&
    irq_enable[rsc_pkg::CPU_DATA])
    else $error("data interrupt without flag and enable");
  ovf_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    sts.rx_valid && rx_full && state == rsc_pkg::RSC_RX &&
    !(rd && paddr == rsc_pkg::OFS_DATA)
    |=> state == rsc_pkg::RSC_ERR &&
    radio_event_flags[rsc_pkg::EV_RXOVF])
    else $error("overflow not caught");
endmodule : rsc_top
`default_nettype wire

// [sim/radio_strobe_and_irq_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module radio_strobe_and_irq_control_bench;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [7:0]        paddr, tx_byte, ev, rx_val;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, er, clr, rx_go, tx_go;
  logic              irq_data_transfer, irq_general;
  rsc_pkg::rsc_sts_s sts;
  rsc_pkg::rsc_ctl_s ctl;
  int                n_fail, n_checks;
  // state just after each strobe 0..3, autocal off then on; then settled
  localparam logic [8:0] FIRST [0:7] = '{9'h020, 9'h002, 9'h040, 9'h080,
    9'h004, 9'h002, 9'h008, 9'h010};
  localparam logic [8:0] SETTLED [0:3] = '{9'h020, 9'h001, 9'h040, 9'h080};
  localparam logic [7:0] NOPS [0:2] = '{8'h05, 8'h7F, 8'hFF};

  rsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sts(sts),
    .ctl(ctl), .tx_byte(tx_byte), .irq_data_transfer(irq_data_transfer),
    .irq_general(irq_general));
  rsc_radio_model i_radio (.pclk(pclk), .presetn(presetn), .ctl(ctl),
    .ev(ev), .clr(clr), .rx_go(rx_go), .rx_val(rx_val), .tx_go(tx_go),
    .sts(sts));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one apb transfer; starts on the next edge so nothing is driven twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (n >= 16) check("pready", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, rd, exp);
  endtask : rchk

  task automatic strobe(input logic [7:0] code);
    apb(1'b1, rsc_pkg::OFS_STROBE, {24'h00_0000, code});
  endtask : strobe

  // one received byte, as a single-cycle strobe
  task automatic pulse_rx(input logic [7:0] b);
    @(posedge pclk);
    rx_go <= 1'b1;
    rx_val <= b;
    @(posedge pclk);
    rx_go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse_rx

  // one transmit byte request, as a single-cycle strobe
  task automatic pulse_tx();
    @(posedge pclk);
    tx_go <= 1'b1;
    @(posedge pclk);
    tx_go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse_tx

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ev = 8'h00;
    clr = 1'b0;
    rx_go = 1'b0;
    tx_go = 1'b0;
    rx_val = 8'h00;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("reset state", rsc_pkg::OFS_STROBE, 32'h1);
    for (int i = 1; i < 7; i++) rchk("reg reset", 8'(4 * i), 32'h0);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check("slverr", {31'h0, er}, 32'h1);
    // every strobe code, without and with auto calibration
    for (int c = 0; c < 2; c++) begin
      wr(rsc_pkg::OFS_CONFIG, 32'(c));
      for (int k = 0; k < 4; k++) begin
        strobe(8'(k));
        rchk("strobe", 8'h00, {23'h0, FIRST[c*4+k]});
        repeat (12) @(posedge pclk);
        rchk("settled", 8'h00, {23'h0, SETTLED[k]});
        if (k == 2) check("ctl rx", {28'h0, ctl}, 32'hA);
        strobe(rsc_pkg::idle_strobe);
        rchk("idle", 8'h00, 32'h1);
      end
    end
    foreach (NOPS[i]) begin
      strobe(NOPS[i]);
      rchk("nop", 8'h00, 32'h1);
    end
    // transmit from receive with cca: busy then clear channel
    wr(rsc_pkg::OFS_CONFIG, 32'h2);
    strobe(rsc_pkg::receive_strobe);
    strobe(rsc_pkg::transmit_strobe);
    rchk("cca busy", 8'h00, 32'h40);
    strobe(rsc_pkg::synth_on_strobe);
    rchk("rx to synth", 8'h00, 32'h20);
    strobe(rsc_pkg::receive_strobe);
    clr <= 1'b1;
    strobe(rsc_pkg::transmit_strobe);
    rchk("cca clear", 8'h00, 32'h80);
    strobe(rsc_pkg::idle_strobe);
    clr <= 1'b0;
    // events: masking, write-zero clear, level does not retrigger
    wr(rsc_pkg::OFS_CPUFLG, 32'h3);
    wr(rsc_pkg::OFS_EVMASK, 32'h1);
    wr(rsc_pkg::OFS_IRQEN, 32'h3);
    ev <= 8'h08;
    rchk("unmasked ev", rsc_pkg::OFS_EVFLAG, 32'h08);
    rchk("no cpu flag", rsc_pkg::OFS_CPUFLG, 32'h0);
    ev <= 8'h09;
    rchk("masked ev", rsc_pkg::OFS_EVFLAG, 32'h09);
    check("irq general", {31'h0, irq_general}, 32'h1);
    wr(rsc_pkg::OFS_EVFLAG, 32'hF7);
    rchk("zero clear", rsc_pkg::OFS_EVFLAG, 32'h01);
    wr(rsc_pkg::OFS_EVFLAG, 32'h0);
    wr(rsc_pkg::OFS_CPUFLG, 32'h2);
    rchk("level held", rsc_pkg::OFS_EVFLAG, 32'h0);
    check("irq gen off", {31'h0, irq_general}, 32'h0);
    ev <= 8'h00;
    wr(rsc_pkg::OFS_IRQEN, 32'h1);
    ev <= 8'h01;
    rchk("cpu flag", rsc_pkg::OFS_CPUFLG, 32'h2);
    check("irq gen gated", {31'h0, irq_general}, 32'h0);
    // receive data, gating, then overflow and recovery
    wr(rsc_pkg::OFS_CPUFLG, 32'h3);
    wr(rsc_pkg::OFS_EVFLAG, 32'h0);
    wr(rsc_pkg::OFS_CONFIG, 32'h0);
    strobe(rsc_pkg::receive_strobe);
    pulse_rx(8'hA5);
    check("irq data", {31'h0, irq_data_transfer}, 32'h1);
    rchk("rx byte", rsc_pkg::OFS_DATA, 32'hA5);
    wr(rsc_pkg::OFS_CPUFLG, 32'h1);
    wr(rsc_pkg::OFS_IRQEN, 32'h0);
    pulse_rx(8'h3C);
    check("irq data gated", {31'h0, irq_data_transfer}, 32'h0);
    pulse_rx(8'h5A);
    rchk("overflow", 8'h00, 32'h100);
    rchk("ovf flags", rsc_pkg::OFS_EVFLAG, 32'h50);
    strobe(rsc_pkg::idle_strobe);
    rchk("recovered", 8'h00, 32'h1);
    // transmit: queued byte handed over on request, then underflow
    wr(rsc_pkg::OFS_CPUFLG, 32'h3);
    wr(rsc_pkg::OFS_EVFLAG, 32'h0);
    wr(rsc_pkg::OFS_IRQEN, 32'h1);
    wr(rsc_pkg::OFS_DATA, 32'hC3);
    strobe(rsc_pkg::transmit_strobe);
    check("irq tx idle", {31'h0, irq_data_transfer}, 32'h0);
    pulse_tx();
    check("tx byte", {24'h0, tx_byte}, 32'hC3);
    check("irq tx", {31'h0, irq_data_transfer}, 32'h1);
    pulse_tx();
    rchk("underflow", 8'h00, 32'h100);
    rchk("unf flags", rsc_pkg::OFS_EVFLAG, 32'h90);
    strobe(rsc_pkg::idle_strobe);
    rchk("tx recovered", 8'h00, 32'h1);
    print_verdict();
  end
endmodule : radio_strobe_and_irq_control_bench
`default_nettype wire

// [sim/rsc_radio_model.sv]
`timescale 1ns/100ps
`default_nettype none
// baseband stand-in: finishes calibration late, drives event levels
module rsc_radio_model #(
  parameter int CAL_WAIT = 8
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // controls from the block
  input  wire rsc_pkg::rsc_ctl_s ctl,
  // bench knobs
  input  wire logic [7:0]        ev,
  input  wire logic              clr,
  input  wire logic              rx_go,
  input  wire logic [7:0]        rx_val,
  input  wire logic              tx_go,
  // status towards the block
  output var  rsc_pkg::rsc_sts_s sts
);
  int         cnt;
  logic [7:0] last;

  // slow calibration so the calibrating states can be read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      last <= 8'h00;
    end else begin
      cnt <= ctl.calibrate ? cnt + 1 : 0;
      if (rx_go) last <= rx_val;
    end
  end

  // byte lines are junk outside the strobe; tx asks only when told
  always_comb begin
    sts.events = ev;
    sts.channel_clear = clr;
    sts.cal_done = (cnt == CAL_WAIT);
    sts.rx_valid = rx_go;
    sts.rx_byte = rx_go ? rx_val : ~last;
    sts.tx_req = tx_go;
  end
endmodule : rsc_radio_model
`default_nettype wire
